// ---- hw/dtc_pkg.sv ----
/*
  package for the dual timer control and clock select block: register offsets,
  field positions, reset values, prescale divisors and shared structs.
  assumes a plain register port with 8-bit data and byte offsets.
*/
// How it works
// - overflow flags set by hardware, cleared on vector
// - run bit enables timer, subject to gate
// - external flag set on edge or level
// - level mode: flag set while input active, cleared only by software write
// - type bit picks level or edge
// - gate bit requires active external input
// - count select: clock or falling pin edges
// - second timer modes 13, 16, 8-reload, off
// - first timer mode three splits two bytes
// - second clock select: prescaled or system clock
// - first clock select: prescaled or system clock
// - prescale divides by 12, 4, 48, ext/8
// - external clock synchronised; must be slower
// - fourth high select only in split mode
// - fourth low select clocks whole or low
// - third timer selects behave like fourth
// - count bytes readable and writable
// - 13-bit mode overflows at 0x1fff
// - 8-bit mode reloads low from high
// - split high byte uses second run and flag
package dtc_pkg;
  localparam logic [7:0] ADDR_CONTROL    = 8'h88;
  localparam logic [7:0] ADDR_MODE       = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW     = 8'h8a;
  localparam logic [7:0] ADDR_T1_LOW     = 8'h8b;
  localparam logic [7:0] ADDR_T0_HIGH    = 8'h8c;
  localparam logic [7:0] ADDR_T1_HIGH    = 8'h8d;
  localparam logic [7:0] ADDR_CLOCK_SEL  = 8'h8f;
  localparam logic [7:0] RESET_VALUE     = 8'h00;
  localparam int CTL_T1_FLAG = 7;
  localparam int CTL_T1_RUN  = 6;
  localparam int CTL_T0_FLAG = 5;
  localparam int CTL_T0_RUN  = 4;
  localparam int CTL_B_FLAG  = 3;
  localparam int CTL_B_EDGE  = 2;
  localparam int CTL_A_FLAG  = 1;
  localparam int CTL_A_EDGE  = 0;
  localparam int CK_T3H = 7;
  localparam int CK_T3L = 6;
  localparam int CK_T2H = 5;
  localparam int CK_T2L = 4;
  localparam int CK_T1M = 3;
  localparam int CK_T0M = 2;
  localparam logic [5:0] DIV_BY_12 = 6'h0c;
  localparam logic [5:0] DIV_BY_4  = 6'h04;
  localparam logic [5:0] DIV_BY_48 = 6'h30;
  localparam logic [2:0] EXT_DIV   = 3'h7;
  typedef enum logic [1:0] {
    DTC_MODE13, DTC_MODE16, DTC_MODE8R, DTC_MODE_SPLIT
  } dtc_mode_t;
  typedef struct packed {
    logic       gate;
    logic       count_sel;
    dtc_mode_t  mode;
  } dtc_tcfg_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dtc_bus_t;
  typedef struct packed {
    logic third_low;
    logic third_high;
    logic fourth_low;
    logic fourth_high;
  } dtc_clksel_t;
endpackage

// ---- hw/dtc_prescaler.sv ----
/*
  shared prescaler for the first and second timer.
  assumes ext_clk_sync is already synchronised to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dtc_prescaler (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [1:0] prescale_select,
  input  wire logic       ext_clk_sync,
  output logic            tick
);
  import dtc_pkg::*;
  logic [5:0] div_cnt;
  logic [5:0] div_max;
  logic [2:0] ext_cnt;
  logic       ext_prev;
  logic       ext_fall;

  always_comb begin
    case (prescale_select)
      2'h0:    div_max = DIV_BY_12 - 6'h01;
      2'h1:    div_max = DIV_BY_4 - 6'h01;
      2'h2:    div_max = DIV_BY_48 - 6'h01;
      default: div_max = 6'h00;
    endcase
  end

  assign ext_fall = ext_prev & ~ext_clk_sync;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt  <= 6'h00;
      ext_cnt  <= 3'h0;
      ext_prev <= 1'b0;
      tick     <= 1'b0;
    end else if (clk_en) begin
      ext_prev <= ext_clk_sync;
      if (prescale_select == 2'h3) begin
        // external edges counted in the system domain; ext/8
        tick <= ext_fall && (ext_cnt == EXT_DIV);
        if (ext_fall) begin
          ext_cnt <= ext_cnt + 3'h1;
        end
        div_cnt <= 6'h00;
      end else begin
        tick <= (div_cnt >= div_max);
        div_cnt <= (div_cnt >= div_max) ? 6'h00 : div_cnt + 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/dtc_timer_ctl.sv ----
/*
  control, mode and clock select for the first and second timers, the two
  external interrupt flags, and clock select bits for the third and fourth
  timers. assumes pins are asynchronous, polarity bits and split flags come
  from elsewhere on ref_clk, and ack pulses are one cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_ctl (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  input  wire dtc_pkg::dtc_bus_t   bus,
  output logic [7:0]               rdata,
  input  wire logic                first_timer_count_pin,
  input  wire logic                second_timer_count_pin,
  input  wire logic                ext_irq_a_input,
  input  wire logic                ext_irq_b_input,
  input  wire logic                ext_irq_a_polarity,
  input  wire logic                ext_irq_b_polarity,
  input  wire logic                ext_clock,
  input  wire logic                first_timer_ack,
  input  wire logic                second_timer_ack,
  input  wire logic                ext_irq_a_ack,
  input  wire logic                ext_irq_b_ack,
  input  wire logic                third_timer_split,
  input  wire logic                fourth_timer_split,
  output dtc_pkg::dtc_clksel_t     clock_system,
  output logic                     first_timer_overflow_flag,
  output logic                     second_timer_overflow_flag,
  output logic                     ext_irq_a_flag,
  output logic                     ext_irq_b_flag,
  output logic                     second_timer_overflow
);
  import dtc_pkg::*;
  // pin synchronisers: stage one is read only by stage two
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] pins;
  logic       pin0_prev;
  logic       pin1_prev;
  logic       irq_a_prev;
  logic       irq_b_prev;
  logic [7:0] mode_reg;
  logic [7:0] clock_sel;
  logic       first_timer_run;
  logic       second_timer_run;
  logic       ext_irq_a_edge_select;
  logic       ext_irq_b_edge_select;
  logic [7:0] t0_low;
  logic [7:0] t0_high;
  logic [7:0] t1_low;
  logic [7:0] t1_high;
  logic       pre_tick;
  dtc_tcfg_t  cfg0;
  dtc_tcfg_t  cfg1;
  logic       a_active;
  logic       b_active;
  logic       tick0;
  logic       tick1;
  logic       tick0_high;
  logic       en0;
  logic       en1;
  logic       en0_high;
  logic       ovf0;
  logic       ovf0_high;
  logic       ovf1;
  logic       set_a;
  logic       set_b;
  logic       wr_ctl;
  logic [7:0] next_t0_low;
  logic [7:0] next_t0_high;
  logic [7:0] next_t1_low;
  logic [7:0] next_t1_high;

  assign pins = {ext_clock, ext_irq_b_input, ext_irq_a_input,
                 second_timer_count_pin, first_timer_count_pin};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else if (clk_en) begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  dtc_prescaler u_pre (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .clk_en          (clk_en),
    .prescale_select (clock_sel[1:0]),
    .ext_clk_sync    (sync2[4]),
    .tick            (pre_tick)
  );

  // one function decodes each timer's configuration nibble
  function automatic dtc_tcfg_t decode_cfg(input logic [3:0] nib);
    decode_cfg.gate      = nib[3];
    decode_cfg.count_sel = nib[2];
    decode_cfg.mode      = dtc_mode_t'(nib[1:0]);
  endfunction

  function automatic logic tick_for(input logic count_sel, input logic fall,
                                    input logic sys_sel, input logic pre);
    tick_for = count_sel ? fall : (sys_sel ? 1'b1 : pre);
  endfunction

  assign cfg0 = decode_cfg(mode_reg[3:0]);
  assign cfg1 = decode_cfg(mode_reg[7:4]);

  // active level per polarity; polarity 1 means active high
  assign a_active = ~(sync2[2] ^ ext_irq_a_polarity);
  assign b_active = ~(sync2[3] ^ ext_irq_b_polarity);

  // pin edges: high to low after synchronising; pin must hold two cycles
  assign tick0 = tick_for(cfg0.count_sel, pin0_prev & ~sync2[0],
                          clock_sel[CK_T0M], pre_tick);
  assign tick1 = tick_for(cfg1.count_sel, pin1_prev & ~sync2[1],
                          clock_sel[CK_T1M], pre_tick);
  // split high byte never counts pin edges
  assign tick0_high = clock_sel[CK_T0M] ? 1'b1 : pre_tick;

  assign en0 = first_timer_run & (~cfg0.gate | a_active) & tick0;
  assign en1 = (cfg0.mode == DTC_MODE_SPLIT ? 1'b1 : second_timer_run)
               & (~cfg1.gate | b_active) & tick1
               & (cfg1.mode != DTC_MODE_SPLIT);
  assign en0_high = (cfg0.mode == DTC_MODE_SPLIT) & second_timer_run & tick0_high;

  assign wr_ctl = bus.wr && (bus.addr == ADDR_CONTROL);

  // counting per mode; a software write to a byte replaces its next value
  always_comb begin
    next_t0_low  = t0_low;
    next_t0_high = t0_high;
    next_t1_low  = t1_low;
    next_t1_high = t1_high;
    ovf0         = 1'b0;
    ovf0_high    = 1'b0;
    ovf1         = 1'b0;
    if (en0) begin
      case (cfg0.mode)
        DTC_MODE13: begin
          ovf0 = (t0_high == 8'hff) && (t0_low[4:0] == 5'h1f);
          next_t0_low = {3'h0, t0_low[4:0] + 5'h01};
          if (t0_low[4:0] == 5'h1f) begin
            next_t0_high = t0_high + 8'h01;
          end
        end
        DTC_MODE16: begin
          ovf0 = ({t0_high, t0_low} == 16'hffff);
          {next_t0_high, next_t0_low} = {t0_high, t0_low} + 16'h0001;
        end
        DTC_MODE8R: begin
          ovf0 = (t0_low == 8'hff);
          next_t0_low = ovf0 ? t0_high : t0_low + 8'h01;
        end
        default: begin
          ovf0 = (t0_low == 8'hff);
          next_t0_low = t0_low + 8'h01;
        end
      endcase
    end
    if (en0_high) begin
      ovf0_high = (t0_high == 8'hff);
      next_t0_high = t0_high + 8'h01;
    end
    if (en1) begin
      case (cfg1.mode)
        DTC_MODE13: begin
          ovf1 = (t1_high == 8'hff) && (t1_low[4:0] == 5'h1f);
          next_t1_low = {3'h0, t1_low[4:0] + 5'h01};
          if (t1_low[4:0] == 5'h1f) begin
            next_t1_high = t1_high + 8'h01;
          end
        end
        DTC_MODE16: begin
          ovf1 = ({t1_high, t1_low} == 16'hffff);
          {next_t1_high, next_t1_low} = {t1_high, t1_low} + 16'h0001;
        end
        DTC_MODE8R: begin
          ovf1 = (t1_low == 8'hff);
          next_t1_low = ovf1 ? t1_high : t1_low + 8'h01;
        end
        default: begin
          ovf1 = 1'b0;
        end
      endcase
    end
    if (bus.wr && bus.addr == ADDR_T0_LOW) next_t0_low = bus.wdata;
    if (bus.wr && bus.addr == ADDR_T0_HIGH) next_t0_high = bus.wdata;
    if (bus.wr && bus.addr == ADDR_T1_LOW) next_t1_low = bus.wdata;
    if (bus.wr && bus.addr == ADDR_T1_HIGH) next_t1_high = bus.wdata;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      t0_low  <= RESET_VALUE;
      t0_high <= RESET_VALUE;
      t1_low  <= RESET_VALUE;
      t1_high <= RESET_VALUE;
      second_timer_overflow <= 1'b0;
    end else if (clk_en) begin
      t0_low  <= next_t0_low;
      t0_high <= next_t0_high;
      t1_low  <= next_t1_low;
      t1_high <= next_t1_high;
      // raw overflow still usable as a baud source in split mode
      second_timer_overflow <= ovf1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg  <= RESET_VALUE;
      clock_sel <= RESET_VALUE;
    end else if (clk_en) begin
      if (bus.wr && bus.addr == ADDR_MODE) mode_reg <= bus.wdata;
      if (bus.wr && bus.addr == ADDR_CLOCK_SEL) clock_sel <= bus.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_timer_run       <= 1'b0;
      second_timer_run      <= 1'b0;
      ext_irq_a_edge_select <= 1'b0;
      ext_irq_b_edge_select <= 1'b0;
    end else if (clk_en && wr_ctl) begin
      first_timer_run       <= bus.wdata[CTL_T0_RUN];
      second_timer_run      <= bus.wdata[CTL_T1_RUN];
      ext_irq_a_edge_select <= bus.wdata[CTL_A_EDGE];
      ext_irq_b_edge_select <= bus.wdata[CTL_B_EDGE];
    end
  end

  // edge detect on the synchronised inputs; only the interrupt inputs are polarity-corrected
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin0_prev  <= 1'b0;
      pin1_prev  <= 1'b0;
      irq_a_prev <= 1'b0;
      irq_b_prev <= 1'b0;
    end else if (clk_en) begin
      pin0_prev  <= sync2[0];
      pin1_prev  <= sync2[1];
      irq_a_prev <= a_active;
      irq_b_prev <= b_active;
    end
  end

  assign set_a = ext_irq_a_edge_select ? (a_active & ~irq_a_prev) : a_active;
  assign set_b = ext_irq_b_edge_select ? (b_active & ~irq_b_prev) : b_active;

  // flags: set wins over software write and over the vector clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_timer_overflow_flag  <= 1'b0;
      second_timer_overflow_flag <= 1'b0;
      ext_irq_a_flag             <= 1'b0;
      ext_irq_b_flag             <= 1'b0;
    end else if (clk_en) begin
      if (ovf0) begin
        first_timer_overflow_flag <= 1'b1;
      end else if (wr_ctl) begin
        first_timer_overflow_flag <= bus.wdata[CTL_T0_FLAG];
      end else if (first_timer_ack) begin
        first_timer_overflow_flag <= 1'b0;
      end
      if (ovf0_high || (ovf1 && cfg0.mode != DTC_MODE_SPLIT)) begin
        second_timer_overflow_flag <= 1'b1;
      end else if (wr_ctl) begin
        second_timer_overflow_flag <= bus.wdata[CTL_T1_FLAG];
      end else if (second_timer_ack) begin
        second_timer_overflow_flag <= 1'b0;
      end
      if (set_a) begin
        ext_irq_a_flag <= 1'b1;
      end else if (wr_ctl) begin
        ext_irq_a_flag <= bus.wdata[CTL_A_FLAG];
      end else if (ext_irq_a_ack && ext_irq_a_edge_select) begin
        ext_irq_a_flag <= 1'b0;
      end
      if (set_b) begin
        ext_irq_b_flag <= 1'b1;
      end else if (wr_ctl) begin
        ext_irq_b_flag <= bus.wdata[CTL_B_FLAG];
      end else if (ext_irq_b_ack && ext_irq_b_edge_select) begin
        ext_irq_b_flag <= 1'b0;
      end
    end
  end

  // third and fourth timer selects: 1 means system clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_system <= '0;
    end else if (clk_en) begin
      clock_system.fourth_low  <= clock_sel[CK_T3L];
      clock_system.fourth_high <= fourth_timer_split ? clock_sel[CK_T3H]
                                                     : clock_sel[CK_T3L];
      clock_system.third_low   <= clock_sel[CK_T2L];
      clock_system.third_high  <= third_timer_split ? clock_sel[CK_T2H]
                                                    : clock_sel[CK_T2L];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      rdata <= 8'h00;
      if (bus.rd) begin
        case (bus.addr)
          ADDR_CONTROL:   rdata <= {second_timer_overflow_flag, second_timer_run,
                                    first_timer_overflow_flag, first_timer_run,
                                    ext_irq_b_flag, ext_irq_b_edge_select,
                                    ext_irq_a_flag, ext_irq_a_edge_select};
          ADDR_MODE:      rdata <= mode_reg;
          ADDR_T0_LOW:    rdata <= t0_low;
          ADDR_T0_HIGH:   rdata <= t0_high;
          ADDR_T1_LOW:    rdata <= t1_low;
          ADDR_T1_HIGH:   rdata <= t1_high;
          ADDR_CLOCK_SEL: rdata <= clock_sel;
          default:        rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/dtc_timer_ctl_assertions.sv ----
/* port checker for dtc_timer_ctl, bound to every instance of it below.
   assumes one clock domain and a register port that never waits. */
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_ctl_assertions (
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire logic                 clk_en,
  input wire dtc_pkg::dtc_bus_t    bus,
  input wire logic [7:0]           rdata,
  input wire logic                 ext_irq_a_input,
  input wire logic                 ext_irq_a_polarity,
  input wire logic                 second_timer_ack,
  input wire logic                 first_timer_ack,
  input wire logic                 ext_irq_b_ack,
  input wire logic                 third_timer_split,
  input wire logic                 fourth_timer_split,
  input wire dtc_pkg::dtc_clksel_t clock_system,
  input wire logic                 first_timer_overflow_flag,
  input wire logic                 second_timer_overflow_flag,
  input wire logic                 ext_irq_a_flag,
  input wire logic                 ext_irq_b_flag
);
  import dtc_pkg::*;
  logic [7:0] ctl_sh;
  logic [7:0] ck_sh;
  wire logic  wr_ctl = clk_en && bus.wr && bus.addr == ADDR_CONTROL;
  wire logic  wr_ck = clk_en && bus.wr && bus.addr == ADDR_CLOCK_SEL;
  wire logic  clr_t0 = wr_ctl || (clk_en && first_timer_ack);
  wire logic  clr_b = wr_ctl || (clk_en && ext_irq_b_ack && ctl_sh[CTL_B_EDGE]);
  // shadows of software-only bits, since the design's copies are not ports
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ctl_sh <= 8'h00;
    else if (wr_ctl) ctl_sh <= bus.wdata;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ck_sh <= 8'h00;
    else if (wr_ck) ck_sh <= bus.wdata;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  AST_RDATA_IDLE: assert property (clk_en && !bus.rd |=> rdata == 8'h00)
    else $error("read data not zero after an idle cycle");
  AST_UNMAPPED: assert property (clk_en && bus.rd && bus.addr == 8'h80 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_MODE_RW: assert property (clk_en && bus.wr && bus.addr == ADDR_MODE ##1 !bus.wr
    ##1 clk_en && bus.rd && bus.addr == ADDR_MODE |=> rdata == $past(bus.wdata, 3))
    else $error("mode byte read back differs");
  // six cycles leave room for the input synchroniser
  AST_LEVEL_A: assert property ((clk_en && !ctl_sh[CTL_A_EDGE]
    && ext_irq_a_input == ext_irq_a_polarity) [*6] |-> ext_irq_a_flag)
    else $error("level input active but flag low");
  AST_T0_FALL: assert property ($fell(first_timer_overflow_flag)
    |-> $past(clr_t0))
    else $error("first overflow flag cleared without cause");
  AST_T1_HOLD: assert property (second_timer_overflow_flag
    && !(wr_ctl || (clk_en && second_timer_ack)) |=> second_timer_overflow_flag)
    else $error("second overflow flag cleared without cause");
  AST_B_FALL: assert property ($fell(ext_irq_b_flag)
    |-> $past(clr_b))
    else $error("flag b cleared without cause");
  // outputs lag the select register by one cycle, so no write may land in between
  AST_CLKSEL: assert property (clk_en && !wr_ck
    ##1 $stable({third_timer_split, fourth_timer_split}) |-> clock_system == {ck_sh[CK_T2L],
    third_timer_split ? ck_sh[CK_T2H] : ck_sh[CK_T2L], ck_sh[CK_T3L],
    fourth_timer_split ? ck_sh[CK_T3H] : ck_sh[CK_T3L]})
    else $error("clock select outputs wrong");
  cover property (first_timer_overflow_flag);
  cover property (second_timer_overflow_flag);
  cover property (ext_irq_b_flag && ctl_sh[CTL_B_EDGE]);
endmodule
bind dtc_timer_ctl dtc_timer_ctl_assertions u_dtc_timer_ctl_assertions (
  .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .bus(bus), .rdata(rdata),
  .ext_irq_a_input(ext_irq_a_input), .ext_irq_a_polarity(ext_irq_a_polarity),
  .second_timer_ack(second_timer_ack), .first_timer_ack(first_timer_ack),
  .ext_irq_b_ack(ext_irq_b_ack), .third_timer_split(third_timer_split),
  .fourth_timer_split(fourth_timer_split), .clock_system(clock_system),
  .first_timer_overflow_flag(first_timer_overflow_flag),
  .second_timer_overflow_flag(second_timer_overflow_flag),
  .ext_irq_a_flag(ext_irq_a_flag), .ext_irq_b_flag(ext_irq_b_flag)
);
`default_nettype wire

// ---- verification/dtc_pin_model.sv ----
/* far-side pin model: timer count pins, external interrupt inputs, external clock.
   assumes its tasks are called right after a rising edge of ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input  wire logic ref_clk,
  output logic      first_timer_count_pin,
  output logic      second_timer_count_pin,
  output logic      ext_irq_a_input,
  output logic      ext_irq_b_input,
  output logic      ext_clock
);
  initial begin
    first_timer_count_pin = 1'b1;
    second_timer_count_pin = 1'b1;
    ext_irq_a_input = 1'b0;
    ext_irq_b_input = 1'b0;
    ext_clock = 1'b0;
  end
  // n falling edges; three cycles per level so the sampler never misses one
  task automatic pulse(input logic sel, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      if (sel) second_timer_count_pin <= ~second_timer_count_pin;
      else first_timer_count_pin <= ~first_timer_count_pin;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  task automatic set_irq(input logic a, input logic b);
    ext_irq_a_input <= a;
    ext_irq_b_input <= b;
  endtask
  // eight cycles a period, well below ref_clk; stands still low afterwards
  task automatic ext_run(input int n);
    repeat (n / 8) begin
      ext_clock <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext_clock <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/dual_timer_control_and_clock_select_test.sv ----
/* self-checking bench for dtc_timer_ctl: registers, modes, gate, prescaler,
   flags and clock select. assumes dtc_pin_model on the pin side. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module dual_timer_control_and_clock_select_test;
  import dtc_pkg::*;
  logic        ref_clk, rst_n, clk_en, pin0, pin1, irq_a, irq_b, ext_clk;
  logic [1:0]  pol, spl;
  logic [3:0]  ackv;
  logic [7:0]  rdata, got;
  wire  [3:0]  flg;
  wire         t1_ovf;
  logic        t1_ovf_seen = 1'b0;
  dtc_bus_t    bus;
  dtc_clksel_t csel;
  int          num_errors = 0;
  int          samples_checked = 0;
  logic [7:0]  ra [8] = '{ADDR_CONTROL, ADDR_MODE, ADDR_T0_LOW, ADDR_T1_LOW,
                          ADDR_T0_HIGH, ADDR_T1_HIGH, ADDR_CLOCK_SEL, 8'h80};
  logic [7:0]  rv [8] = '{8'haa, 8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h69, 8'h96, 8'h77};
  logic [7:0]  lo [3] = '{8'h1e, 8'hfe, 8'hfe};
  logic [7:0]  hi [3] = '{8'hff, 8'hff, 8'h80};
  logic [7:0]  hx [3] = '{8'h00, 8'h00, 8'h80};
  logic [7:0]  pe [4] = '{8'h14, 8'h3c, 8'h05, 8'h04};
  dtc_timer_ctl u_dtc_timer_ctl (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .bus(bus), .rdata(rdata),
    .first_timer_count_pin(pin0), .second_timer_count_pin(pin1),
    .ext_irq_a_input(irq_a), .ext_irq_b_input(irq_b), .ext_clock(ext_clk),
    .ext_irq_a_polarity(pol[0]), .ext_irq_b_polarity(pol[1]),
    .first_timer_ack(ackv[2]), .second_timer_ack(ackv[3]), .ext_irq_a_ack(ackv[0]),
    .ext_irq_b_ack(ackv[1]), .third_timer_split(spl[0]), .fourth_timer_split(spl[1]),
    .clock_system(csel), .first_timer_overflow_flag(flg[2]),
    .second_timer_overflow_flag(flg[3]), .ext_irq_a_flag(flg[0]),
    .ext_irq_b_flag(flg[1]), .second_timer_overflow(t1_ovf)
  );
  dtc_pin_model u_dtc_pin_model (
    .ref_clk(ref_clk), .first_timer_count_pin(pin0), .second_timer_count_pin(pin1),
    .ext_irq_a_input(irq_a), .ext_irq_b_input(irq_b), .ext_clock(ext_clk)
  );
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // the raw overflow is a one-cycle pulse, so keep a sticky copy
  always @(posedge ref_clk) begin
    if (t1_ovf) t1_ovf_seen <= 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
    @(posedge ref_clk);
  endtask
  // read data are taken at the edge that ends their only valid cycle
  task automatic rd(input logic [7:0] a);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    @(posedge ref_clk);
    got = rdata;
  endtask
  task automatic pulse_ack(input int i);
    ackv[i] <= 1'b1;
    @(posedge ref_clk);
    ackv[i] <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wait_flag(input int i);
    for (int k = 0; k < 600 && flg[i] !== 1'b1; k++) @(posedge ref_clk);
  endtask
  task automatic conclude();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // the tests take about fourteen hundred cycles
  initial begin
    #300_000;
    num_errors++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    bus = '0;
    ackv = 4'h0;
    pol = 2'b11;
    spl = 2'b00;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK(got, RESET_VALUE)
    end
    foreach (ra[i]) begin
      wr(ra[i], rv[i]);
      rd(ra[i]);
      `CHK(got, (i == 7) ? 8'h00 : rv[i])
    end
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CLOCK_SEL, 8'h04);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_T0_LOW, lo[m]);
      wr(ADDR_T0_HIGH, hi[m]);
      wr(ADDR_MODE, 8'(m));
      wr(ADDR_CONTROL, 8'h10);
      wait_flag(2);
      `CHK(flg[2], 1'b1)
      rd(ADDR_T0_HIGH);
      `CHK(got, hx[m])
      pulse_ack(2);
      `CHK(flg[2], 1'b0)
      wr(ADDR_CONTROL, 8'h00);
    end
    wr(ADDR_MODE, 8'h09);
    wr(ADDR_T0_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h10);
    repeat (20) @(posedge ref_clk);
    rd(ADDR_T0_LOW);
    `CHK(got, 8'h00)
    u_dtc_pin_model.set_irq(1'b1, 1'b0);
    repeat (20) @(posedge ref_clk);
    rd(ADDR_T0_LOW);
    `CHK(got > 8'h08, 1'b1)
    `CHK(flg[0], 1'b1)
    u_dtc_pin_model.set_irq(1'b0, 1'b0);
    repeat (5) @(posedge ref_clk);
    wr(ADDR_CONTROL, 8'h04);
    u_dtc_pin_model.set_irq(1'b0, 1'b1);
    wait_flag(1);
    `CHK(flg[1], 1'b1)
    pulse_ack(1);
    rd(ADDR_CONTROL);
    `CHK(got, 8'h04)
    u_dtc_pin_model.set_irq(1'b0, 1'b0);
    for (int t = 0; t < 2; t++) begin
      wr(ADDR_MODE, t ? 8'h50 : 8'h05);
      wr(t ? ADDR_T1_LOW : ADDR_T0_LOW, 8'h00);
      wr(ADDR_CONTROL, t ? 8'h40 : 8'h10);
      u_dtc_pin_model.pulse(t[0], 5);
      repeat (6) @(posedge ref_clk);
      rd(t ? ADDR_T1_LOW : ADDR_T0_LOW);
      `CHK(got, 8'h05)
      wr(ADDR_CONTROL, 8'h00);
    end
    wr(ADDR_MODE, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_T0_LOW, 8'h00);
      wr(ADDR_CLOCK_SEL, 8'(c));
      wr(ADDR_CONTROL, 8'h10);
      if (c == 3) u_dtc_pin_model.ext_run(240);
      else repeat (240) @(posedge ref_clk);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_T0_LOW);
      `CHK(got >= pe[c] - 8'h01 && got <= pe[c] + 8'h01, 1'b1)
    end
    wr(ADDR_MODE, 8'h03);
    wr(ADDR_T0_HIGH, 8'hfe);
    wr(ADDR_CLOCK_SEL, 8'h0c);
    wr(ADDR_CONTROL, 8'h40);
    wait_flag(3);
    `CHK(flg[3:2], 2'b10)
    pulse_ack(3);
    `CHK(flg[3], 1'b0)
    wr(ADDR_T1_HIGH, 8'hff);
    repeat (40) @(posedge ref_clk);
    `CHK(t1_ovf_seen, 1'b1)
    `CHK(flg[3], 1'b0)
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CLOCK_SEL, 8'h50);
    repeat (3) @(posedge ref_clk);
    `CHK(csel, 4'hf)
    spl <= 2'b11;
    repeat (3) @(posedge ref_clk);
    `CHK(csel, 4'ha)
    clk_en <= 1'b0;
    pol <= 2'b00;
    repeat (5) @(posedge ref_clk);
    `CHK(flg[1:0], 2'b00)
    clk_en <= 1'b1;
    repeat (5) @(posedge ref_clk);
    wr(ADDR_CONTROL, 8'h00);
    `CHK(flg[1:0], 2'b11)
    wr(ADDR_CONTROL, 8'h01);
    pulse_ack(0);
    `CHK(flg[0], 1'b0)
    conclude();
  end
endmodule
`default_nettype wire
